// [core/wdt_map.svh]
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH

// ******************************
// register offsets (byte)
// ******************************
`define WDT_ADDR_CTRL 12'h000
`define WDT_ADDR_CAUSE 12'h004
`define WDT_ADDR_RESTART 12'h008
`define WDT_ADDR_IRQ_STAT 12'h00c
`define WDT_ADDR_IRQ_MASK 12'h010

// ******************************
// field positions
// ******************************
`define WDT_BIT_FLAG 7
`define WDT_BIT_IE 6
`define WDT_BIT_TS3 5
`define WDT_BIT_UNLOCK 4
`define WDT_BIT_WDE 3
`define WDT_TS_LO_HI 2
`define WDT_BIT_CAUSE 3
`define WDT_EV_TIMEOUT 0
`define WDT_EV_RESET 1

// ******************************
// values and counts
// ******************************
`define WDT_TSEL_MAX 4'h9
`define WDT_TSEL_RESET 4'h0
`define WDT_UNLOCK_LAST 3'h3
`define WDT_BASE_CYCLES 2048
`define WDT_OSC_HZ 128000
`define WDT_SYS_HZ 50000000

`endif

// [core/wdt_osc_counter.sv]
`include "wdt_map.svh"
// ******************************
// oscillator cycle counter
// ******************************
module wdt_osc_counter #(
  parameter int P_BASE_CYCLES = `WDT_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_osc_level,
  input wire logic i_restart,
  input wire wdt_pkg::wdt_tsel_t i_tsel,
  output logic o_timeout
);
  import wdt_pkg::*;
  logic prev_q;
  logic prev_d;
  wdt_cnt_t cnt_q;
  wdt_cnt_t cnt_d;
  logic tmo_q;
  logic tmo_d;
  logic [20:0] limit;
  logic osc_rise;

  // count on each synchronised oscillator rising edge
  always_comb begin
    prev_d = i_osc_level;
    osc_rise = i_osc_level & ~prev_q;
    limit = 21'(P_BASE_CYCLES) << i_tsel;
    cnt_d = cnt_q;
    tmo_d = 1'b0;
    if (i_restart) begin
      cnt_d = '0;
    end else if (osc_rise) begin
      if (cnt_q == 20'(limit - 21'h000001)) begin
        cnt_d = '0;
        tmo_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 20'h00001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      prev_q <= 1'b0;
      cnt_q <= '0;
      tmo_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
    end
  end

  assign o_timeout = tmo_q;
endmodule : wdt_osc_counter

// [core/wdt_pkg.sv]
// ******************************
// shared types
// ******************************
package wdt_pkg;
  typedef enum logic [1:0] {
    WDT_STOPPED,
    WDT_IRQ,
    WDT_RST,
    WDT_IRQ_RST
  } wdt_mode_t;
  typedef logic [3:0] wdt_tsel_t;
  typedef logic [19:0] wdt_cnt_t;
endpackage : wdt_pkg

// [core/wdt_sync2.sv]
// ******************************
// two-flop level synchroniser
// ******************************
module wdt_sync2 (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_level,
  output logic o_level
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // first stage feeds only the second
  always_comb begin
    meta_d = i_level;
    sync_d = meta_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign o_level = sync_q;
endmodule : wdt_sync2

// [core/wdt_top.sv]
`include "wdt_map.svh"
// ******************************
// watchdog with apb registers
// ******************************
module wdt_top #(
  parameter int P_BASE_CYCLES = `WDT_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_por,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_osc_clk,
  input wire logic i_force_reset_fuse_n,
  input wire logic i_global_irq_en,
  input wire logic i_vector_ack,
  input wire logic i_restart_instr,
  output logic o_wdt_irq,
  output logic o_sys_reset,
  output logic o_int
);
  import wdt_pkg::*;

  // ******************************
  // declarations
  // ******************************
  logic flag_q, flag_d, ie_q, ie_d, wde_q, wde_d;
  logic unlock_q, unlock_d, cause_q, cause_d;
  logic [2:0] ucnt_q, ucnt_d;
  wdt_tsel_t tsel_q, tsel_d, tsel_wr;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic irq_q, irq_d, sysrst_q, sysrst_d, int_q, int_d;
  logic osc_sync, tmo, fuse_prog, wde_eff, ie_eff, running;
  logic access, wr, wr_ctrl, wr_cause, wr_restart, wr_stat, wr_mask;
  logic hit, unlock_start, tmo_irq, tmo_rst, restart;
  logic [7:0] ctrl_rd;
  wdt_mode_t mode;

  // ******************************
  // oscillator path
  // ******************************
  wdt_sync2 u_sync (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_level(i_osc_clk),
    .o_level(osc_sync)
  );

  wdt_osc_counter #(.P_BASE_CYCLES(P_BASE_CYCLES)) u_cnt (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_osc_level(osc_sync),
    .i_restart(restart),
    .i_tsel(tsel_q),
    .o_timeout(tmo)
  );

  // ******************************
  // mode decode
  // ******************************
  // fuse overrides both stored enables; cause flag forces only the reset enable
  always_comb begin
    fuse_prog = ~i_force_reset_fuse_n;
    wde_eff = wde_q | cause_q | fuse_prog;
    ie_eff = ie_q & ~fuse_prog;
    unique case ({wde_eff, ie_eff})
      2'b00: mode = WDT_STOPPED;
      2'b01: mode = WDT_IRQ;
      2'b10: mode = WDT_RST;
      2'b11: mode = WDT_IRQ_RST;
    endcase
    running = (mode != WDT_STOPPED);
    // a stopped watchdog holds its counter at zero
    restart = i_restart_instr | wr_restart | ~running;
    tmo_irq = tmo & ((mode == WDT_IRQ) |
      ((mode == WDT_IRQ_RST) & ~flag_q));
    tmo_rst = tmo & ((mode == WDT_RST) |
      ((mode == WDT_IRQ_RST) & flag_q));
  end

  // ******************************
  // apb decode
  // ******************************
  // one wait state so read data comes from a flop
  always_comb begin
    access = i_psel & i_penable & pready_q;
    wr = access & i_pwrite;
    wr_ctrl = wr & (i_paddr == `WDT_ADDR_CTRL);
    wr_cause = wr & (i_paddr == `WDT_ADDR_CAUSE);
    wr_restart = wr & (i_paddr == `WDT_ADDR_RESTART);
    wr_stat = wr & (i_paddr == `WDT_ADDR_IRQ_STAT);
    wr_mask = wr & (i_paddr == `WDT_ADDR_IRQ_MASK);
    hit = (i_paddr == `WDT_ADDR_CTRL) | (i_paddr == `WDT_ADDR_CAUSE) |
      (i_paddr == `WDT_ADDR_RESTART) | (i_paddr == `WDT_ADDR_IRQ_STAT) |
      (i_paddr == `WDT_ADDR_IRQ_MASK);
    unlock_start = wr_ctrl & i_pwdata[`WDT_BIT_UNLOCK] &
      i_pwdata[`WDT_BIT_WDE];
    tsel_wr = {i_pwdata[`WDT_BIT_TS3], i_pwdata[`WDT_TS_LO_HI:0]};
    ctrl_rd = {flag_q, ie_eff, tsel_q[3], unlock_q, wde_eff, tsel_q[2:0]};
  end

  // response and read data
  always_comb begin
    pready_d = i_psel & i_penable & ~pready_q;
    pslverr_d = pready_d & ~hit;
    prdata_d = '0;
    if (pready_d & ~i_pwrite) begin
      unique case (i_paddr)
        `WDT_ADDR_CTRL: prdata_d = {24'h000000, ctrl_rd};
        `WDT_ADDR_CAUSE: prdata_d[`WDT_BIT_CAUSE] = cause_q;
        `WDT_ADDR_IRQ_STAT: prdata_d = {30'h0, stat_q};
        `WDT_ADDR_IRQ_MASK: prdata_d = {30'h0, mask_q};
        default: prdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // ******************************
  // control and status state
  // ******************************
  // hardware set wins over any clear in the same cycle
  always_comb begin
    flag_d = flag_q;
    if (i_vector_ack) begin
      flag_d = 1'b0;
    end
    if (wr_ctrl & i_pwdata[`WDT_BIT_FLAG]) begin
      flag_d = 1'b0;
    end
    if (tmo_irq) begin
      flag_d = 1'b1;
    end
    ie_d = ie_q;
    if (wr_ctrl) begin
      ie_d = i_pwdata[`WDT_BIT_IE];
    end
    // servicing drops to reset-only; software re-arms later
    if (i_vector_ack & wde_eff) begin
      ie_d = 1'b0;
    end
    wde_d = wde_q;
    if (wr_ctrl & i_pwdata[`WDT_BIT_WDE]) begin
      wde_d = 1'b1;
    end else if (wr_ctrl & unlock_q & ~cause_q) begin
      wde_d = 1'b0;
    end
    tsel_d = tsel_q;
    // reserved codes are dropped, old period kept
    if (wr_ctrl & unlock_q & (tsel_wr <= `WDT_TSEL_MAX)) begin
      tsel_d = tsel_wr;
    end
    cause_d = cause_q;
    if (wr_cause & ~i_pwdata[`WDT_BIT_CAUSE]) begin
      cause_d = 1'b0;
    end
    if (tmo_rst) begin
      cause_d = 1'b1;
    end
  end

  // unlock window: set by the start write, gone four cycles on
  always_comb begin
    unlock_d = unlock_q;
    ucnt_d = ucnt_q;
    if (unlock_start) begin
      unlock_d = 1'b1;
      ucnt_d = '0;
    end else if (wr_ctrl) begin
      unlock_d = 1'b0;
    end else if (unlock_q) begin
      if (ucnt_q == `WDT_UNLOCK_LAST) begin
        unlock_d = 1'b0;
      end
      ucnt_d = ucnt_q + 3'h1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      flag_q <= 1'b0;
      ie_q <= 1'b0;
      wde_q <= 1'b0;
      tsel_q <= `WDT_TSEL_RESET;
      unlock_q <= 1'b0;
      ucnt_q <= '0;
    end else begin
      flag_q <= flag_d;
      ie_q <= ie_d;
      wde_q <= wde_d;
      tsel_q <= tsel_d;
      unlock_q <= unlock_d;
      ucnt_q <= ucnt_d;
    end
  end

  // cause survives the watchdog's own reset; only power-on or a cause write clears it
  always_ff @(posedge i_clk) begin
    if (i_por) begin
      cause_q <= 1'b0;
    end else begin
      cause_q <= cause_d;
    end
  end

  // ******************************
  // interrupts and reset request
  // ******************************
  always_comb begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_stat) begin
      stat_d = stat_q & ~i_pwdata[1:0];
    end
    if (wr_mask) begin
      mask_d = i_pwdata[1:0];
    end
    if (tmo) begin
      stat_d[`WDT_EV_TIMEOUT] = 1'b1;
    end
    if (tmo_rst) begin
      stat_d[`WDT_EV_RESET] = 1'b1;
    end
    int_d = |(stat_q & mask_q);
    irq_d = flag_q & ie_eff & i_global_irq_en;
    sysrst_d = tmo_rst;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stat_q <= '0;
      mask_q <= '0;
      int_q <= 1'b0;
      irq_q <= 1'b0;
      sysrst_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      int_q <= int_d;
      irq_q <= irq_d;
      sysrst_q <= sysrst_d;
    end
  end

  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;
  assign o_wdt_irq = irq_q;
  assign o_sys_reset = sysrst_q;
  assign o_int = int_q;

  // ******************************
  // checks
  // ******************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  irq_mode_set_a: assert property (
    tmo && mode == WDT_IRQ && i_global_irq_en ##1 i_global_irq_en
    |=> irq_q)
    else $error("interrupt mode time-out gave no request");

  first_tmo_a: assert property (
    tmo && mode == WDT_IRQ_RST && !flag_q |=> flag_q && !sysrst_q)
    else $error("first combined time-out misbehaved");

  vector_clear_a: assert property (
    i_vector_ack && wde_eff && !tmo_irq && !wr_ctrl |=> !flag_q && !ie_q)
    else $error("vector did not clear enable and flag");

  unserviced_rst_a: assert property (
    tmo && mode == WDT_IRQ_RST && flag_q |=> sysrst_q ##1 !sysrst_q)
    else $error("unserviced time-out gave no reset pulse");

  stopped_quiet_a: assert property (
    mode == WDT_STOPPED |=> !sysrst_q && !$rose(flag_q))
    else $error("stopped watchdog acted");

  fuse_reset_a: assert property (
    fuse_prog && tmo |=> sysrst_q && cause_q && !ie_eff)
    else $error("programmed fuse did not force reset");

  locked_change_a: assert property (
    wr_ctrl && !unlock_q && !i_pwdata[`WDT_BIT_WDE] |=>
    $stable(tsel_q) && wde_q == $past(wde_q))
    else $error("locked field changed without unlock");

  unlock_expiry_a: assert property (
    unlock_start ##1 (!wr_ctrl)[*4] |=> !unlock_q)
    else $error("change unlock outlived four cycles");

  unlock_open_a: assert property (
    unlock_start ##1 (!wr_ctrl)[*3] |-> unlock_q)
    else $error("change unlock closed early");

  // a set cause flag must refuse any control-write clear of the stored reset enable
  cause_forces_a: assert property (
    cause_q && wde_q |=> wde_q && ctrl_rd[`WDT_BIT_WDE])
    else $error("reset enable not forced by cause flag");

  flag_w1c_a: assert property (
    wr_ctrl && i_pwdata[`WDT_BIT_FLAG] && !tmo_irq |=> !flag_q)
    else $error("write one did not clear flag");

  combined_first_c: cover property (
    tmo && mode == WDT_IRQ_RST && !flag_q);
  unlock_change_c: cover property (
    unlock_start ##[1:4] wr_ctrl && !i_pwdata[`WDT_BIT_WDE]);
  reset_issue_c: cover property (sysrst_q);
endmodule : wdt_top

// [testbench/wdt_top_tb.sv]
`include "wdt_map.svh"
module wdt_top_tb import wdt_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  // short base count keeps each period to at most 16 osc edges
  localparam int P_BASE = 4;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic i_por = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0;
  logic i_osc_clk = 1'b0;
  logic i_fuse_n = 1'b1;
  logic i_gie = 1'b1;
  logic i_vector_ack = 1'b0;
  logic i_restart_instr = 1'b0;
  logic o_pready, o_pslverr, o_wdt_irq, o_sys_reset, o_int;
  logic [31:0] o_prdata;
  logic slverr;
  int checks = 0;
  int mismatches = 0;
  int rst_cnt = 0;

  // 50 mhz system clock
  always #10 i_clk = ~i_clk;

  // count reset pulses mid-cycle, away from the launching edge
  always @(negedge i_clk) begin
    if (o_sys_reset === 1'b1) begin
      rst_cnt++;
    end
  end

  wdt_top #(.P_BASE_CYCLES(P_BASE)) DUT (
    .i_clk(i_clk), .i_reset(i_reset), .i_por(i_por),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_osc_clk(i_osc_clk),
    .i_force_reset_fuse_n(i_fuse_n), .i_global_irq_en(i_gie),
    .i_vector_ack(i_vector_ack), .i_restart_instr(i_restart_instr),
    .o_wdt_irq(o_wdt_irq), .o_sys_reset(o_sys_reset), .o_int(o_int)
  );

  // ****************************
  // helpers
  // ****************************
  function automatic logic [31:0] ctl(input logic f, input logic ie,
                                      input logic reset_on_timeout_enable, input wdt_tsel_t ts);
    return {24'h0, f, ie, ts[3], 1'b0, reset_on_timeout_enable, ts[2:0]};
  endfunction : ctl

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic chkb(input string what, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %b seen %b", what, e, g);
    end
  endtask : chkb

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  // psel held high when another transfer follows at once
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     input logic last);
    int n;
    n = 0;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= wd;
    @(posedge i_clk);
    i_penable <= 1'b1;
    // ready, data and error are all taken at the completing edge
    do begin
      @(posedge i_clk);
      n++;
    end while (o_pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      mismatches++;
      print_verdict();
    end
    rd = o_prdata;
    slverr = o_pslverr;
    i_penable <= 1'b0;
    if (last) begin
      i_psel <= 1'b0;
      @(posedge i_clk);
    end
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, x, 1'b1);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    apb(1'b0, a, 32'h0, d, 1'b1);
  endtask : rd

  // timed unlock, then new values in the very next transfer
  task automatic cfg(input logic [31:0] nv);
    logic [31:0] x;
    apb(1'b1, `WDT_ADDR_CTRL, nv | 32'h18, x, 1'b0);
    apb(1'b1, `WDT_ADDR_CTRL, nv, x, 1'b1);
  endtask : cfg

  task automatic osc(input int n);
    repeat (n) begin
      i_osc_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_osc_clk <= 1'b0;
      repeat (4) @(posedge i_clk);
    end
  endtask : osc

  // outputs are read mid-cycle once registered updates have landed
  task automatic settle;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle

  // random partial count, restart, then exact period
  task automatic tmo(input int n);
    logic [31:0] v;
    wr(`WDT_ADDR_RESTART, 32'h0);
    osc($urandom_range(n - 1, 1));
    i_restart_instr <= 1'b1;
    @(posedge i_clk);
    i_restart_instr <= 1'b0;
    osc(n - 1);
    rd(`WDT_ADDR_CTRL, v);
    chkb("early flag", 1'b0, v[7]);
    osc(1);
    rd(`WDT_ADDR_CTRL, v);
    chkb("flag", 1'b1, v[7]);
  endtask : tmo

  // ****************************
  // main sequence
  // ****************************
  initial begin
    logic [31:0] v;
    v = $urandom(32'h33fb);
    repeat (20) @(posedge i_clk);
    i_reset <= 1'b0;
    i_por <= 1'b0;
    @(posedge i_clk);
    rd(`WDT_ADDR_CTRL, v);
    chk("ctrl", 32'h0, v);
    rd(12'h020, v);
    chk("unmapped", 32'h0, v);
    chkb("slverr", 1'b1, slverr);
    done("reset");
    wr(`WDT_ADDR_CTRL, 32'h40);
    wr(`WDT_ADDR_IRQ_MASK, 32'h1);
    for (int c = 0; c < 3; c++) begin
      if (c > 0) begin
        cfg(ctl(1'b0, 1'b1, 1'b0, 4'(c)));
      end
      tmo(P_BASE << c);
      settle();
      chkb("irq", 1'b1, o_wdt_irq);
      chkb("int", 1'b1, o_int);
      @(posedge i_clk);
      i_gie <= 1'b0;
      settle();
      chkb("irq gated", 1'b0, o_wdt_irq);
      @(posedge i_clk);
      i_gie <= 1'b1;
      rd(`WDT_ADDR_IRQ_STAT, v);
      chk("status", 32'h1, v);
      wr(`WDT_ADDR_IRQ_MASK, 32'h0);
      settle();
      chkb("int masked", 1'b0, o_int);
      @(posedge i_clk);
      wr(`WDT_ADDR_IRQ_STAT, 32'h1);
      wr(`WDT_ADDR_IRQ_MASK, 32'h1);
      wr(`WDT_ADDR_CTRL, ctl(1'b1, 1'b1, 1'b0, 4'(c)));
      rd(`WDT_ADDR_CTRL, v);
      chk("flag w1c", ctl(1'b0, 1'b1, 1'b0, 4'(c)), v);
      settle();
      chkb("int cleared", 1'b0, o_int);
      @(posedge i_clk);
    end
    done("interrupt mode");
    wr(`WDT_ADDR_CTRL, ctl(1'b0, 1'b1, 1'b0, 4'h5));
    rd(`WDT_ADDR_CTRL, v);
    chk("locked tsel", ctl(1'b0, 1'b1, 1'b0, 4'h2), v);
    cfg(ctl(1'b0, 1'b1, 1'b0, 4'($urandom_range(15, 10))));
    rd(`WDT_ADDR_CTRL, v);
    chk("reserved tsel", ctl(1'b0, 1'b1, 1'b0, 4'h2), v);
    apb(1'b1, `WDT_ADDR_CTRL, 32'h58, v, 1'b1);
    repeat (6) @(posedge i_clk);
    wr(`WDT_ADDR_CTRL, ctl(1'b0, 1'b1, 1'b0, 4'h1));
    rd(`WDT_ADDR_CTRL, v);
    chk("late change", ctl(1'b0, 1'b1, 1'b1, 4'h2), v);
    done("unlock");
    cfg(ctl(1'b0, 1'b1, 1'b1, 4'h0));
    tmo(P_BASE);
    chk("no reset first", 32'h0, rst_cnt);
    i_vector_ack <= 1'b1;
    @(posedge i_clk);
    i_vector_ack <= 1'b0;
    rd(`WDT_ADDR_CTRL, v);
    chk("after vector", ctl(1'b0, 1'b0, 1'b1, 4'h0), v);
    wr(`WDT_ADDR_CTRL, 32'h48);
    wr(`WDT_ADDR_RESTART, 32'h0);
    osc(P_BASE);
    rd(`WDT_ADDR_CTRL, v);
    chkb("rearmed flag", 1'b1, v[7]);
    chk("still no reset", 32'h0, rst_cnt);
    osc(P_BASE);
    chk("reset issued", 32'h1, rst_cnt);
    rd(`WDT_ADDR_CAUSE, v);
    chk("cause", 32'h8, v);
    rd(`WDT_ADDR_IRQ_STAT, v);
    chkb("reset status", 1'b1, v[1]);
    cfg(32'h80);
    rd(`WDT_ADDR_CTRL, v);
    chk("wde forced", 32'h08, v);
    wr(`WDT_ADDR_CAUSE, 32'h0);
    cfg(32'h0);
    rd(`WDT_ADDR_CTRL, v);
    chk("wde cleared", 32'h0, v);
    done("combined mode");
    wr(`WDT_ADDR_RESTART, 32'h0);
    osc(2 * P_BASE);
    rd(`WDT_ADDR_CTRL, v);
    chk("stopped ctrl", 32'h0, v);
    chk("stopped resets", 32'h1, rst_cnt);
    i_fuse_n <= 1'b0;
    wr(`WDT_ADDR_CTRL, 32'h40);
    rd(`WDT_ADDR_CTRL, v);
    chk("fuse ctrl", 32'h08, v);
    wr(`WDT_ADDR_RESTART, 32'h0);
    osc(P_BASE);
    chk("fuse reset", 32'h2, rst_cnt);
    done("fuse");
    // mid-run reset: cause flag and its forced reset enable survive
    i_fuse_n <= 1'b1;
    i_reset <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    rd(`WDT_ADDR_CTRL, v);
    chk("ctrl after reset", 32'h08, v);
    rd(`WDT_ADDR_CAUSE, v);
    chk("cause kept", 32'h8, v);
    chk("resets after reset", 32'h2, rst_cnt);
    done("mid-run reset");
    print_verdict();
  end
endmodule : wdt_top_tb
